// ---- logic/gate_ctrl_pkg.sv ----
package gate_ctrl_pkg;
  localparam logic [11:0] RUN_GATE_OFS = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFS = 12'h124;
  localparam logic [11:0] RUN_CLK_CFG_OFS = 12'h060;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h200;
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h204;
  localparam logic [11:0] IRQ_CLEAR_OFS = 12'h208;
  localparam int AUTO_GATING_BIT = 27;
  localparam int COMP_LSB = 24;
  localparam int COMP_MSB = 26;
  localparam int TIMER_LSB = 16;
  localparam int TIMER_MSB = 19;
  localparam int TWO_WIRE_ONE_BIT = 14;
  localparam int TWO_WIRE_ZERO_BIT = 12;
  localparam int QUAD_BIT = 8;
  localparam int SYNC_SER_ONE_BIT = 5;
  localparam int SYNC_SER_ZERO_BIT = 4;
  localparam int ASYNC_SER_MSB = 2;
  localparam logic [31:0] GATE_WMASK = 32'h070F5137;
  localparam logic [31:0] GATE_RESET = 32'h00000000;
  localparam logic [31:0] CFG_RESET = 32'h00000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP = 2'b10
  } power_mode_t;
endpackage

// ---- logic/gate_ctrl.sv ----
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps
// What this block does
// - A unit gets its clock enable high only while its active gate bit is one.
// - An access to a unit whose gate is off is flagged on o_access_fault and o_fault_units and sets sticky status; the bus still responds OKAY.
// - All gate bits reset to zero so every unit starts unclocked.
// - Separate run, sleep and deep-sleep gate registers exist; this block holds all three.
// - Sleep and deep-sleep sets apply only with auto gating set; otherwise run set holds.
// - Comparator gates sit at bits 26..24 and timer gates at bits 19..16.
// - Reserved bits are read-only and read as zero.
// - The deep-sleep register sits at offset 0x124 and reads back the unit bits that were written.
// - Bit positions without a unit store nothing and have no effect.
// - Low half holds two-wire, quadrature, sync serial and async serial gates, reset zero.
module gate_ctrl
#(
  parameter int DATA_W = 32,
  parameter int DEC_W = 12
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [DATA_W-1:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [DATA_W-1:0] i_hwdata,
  input wire logic i_hready,
  input wire logic i_sleep,
  input wire logic i_deep_sleep,
  input wire logic [31:0] i_unit_access,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [DATA_W-1:0] o_hrdata,
  output logic [31:0] o_gate_en,
  output logic o_access_fault,
  output logic [31:0] o_fault_units,
  output logic o_irq
);
  import gate_ctrl_pkg::*;

  logic [31:0] run_gate_enables_one_r;
  logic [31:0] sleep_gate_enables_one_r;
  logic [31:0] deep_sleep_gate_enables_one_r;
  logic [31:0] run_clock_config_r;
  logic [31:0] irq_status_r;
  logic [31:0] irq_enable_r;
  logic wr_pend_r;
  logic [DEC_W-1:0] wr_addr_r;
  logic [31:0] irq_status_nxt;
  logic [31:0] gate_en_nxt;
  logic [31:0] rd_nxt;
  logic [31:0] fault_nxt;
  logic [31:0] wdata_gate;
  logic [31:0] cur_run;
  logic [31:0] cur_sleep;
  logic [31:0] cur_deep;
  logic [31:0] cur_cfg;
  logic [31:0] cur_en;
  logic [31:0] clr_mask;
  logic addr_phase;
  logic rd_req;
  logic wr_req;
  logic [DEC_W-1:0] ap_addr;
  logic wr_run;
  logic wr_sleep;
  logic wr_deep;
  logic wr_cfg;
  logic wr_en;
  logic wr_clr;
  logic auto_gating_select;
  power_mode_t mode;

  // Unit fields composed from their bit positions
  localparam logic [31:0] ONE_BIT = 32'h00000001;
  localparam logic [31:0] COMP_FIELD =
    ((ONE_BIT << (COMP_MSB - COMP_LSB + 1)) - ONE_BIT) << COMP_LSB;
  localparam logic [31:0] TIMER_FIELD =
    ((ONE_BIT << (TIMER_MSB - TIMER_LSB + 1)) - ONE_BIT) << TIMER_LSB;
  localparam logic [31:0] ASYNC_FIELD = (ONE_BIT << (ASYNC_SER_MSB + 1)) - ONE_BIT;
  localparam logic [31:0] SINGLE_FIELDS = (ONE_BIT << TWO_WIRE_ONE_BIT)
    | (ONE_BIT << TWO_WIRE_ZERO_BIT) | (ONE_BIT << QUAD_BIT)
    | (ONE_BIT << SYNC_SER_ONE_BIT) | (ONE_BIT << SYNC_SER_ZERO_BIT);
  localparam logic [31:0] UNIT_FIELDS = COMP_FIELD | TIMER_FIELD | ASYNC_FIELD | SINGLE_FIELDS;

  // Refuse settings the decode and word-wide registers cannot serve
  generate
    if (DATA_W != 32 || DEC_W != 12 || UNIT_FIELDS != GATE_WMASK)
    begin : g_bad_setup
      $error("gate_ctrl: unsupported parameters or unit layout");
    end
  endgenerate

  // Address phase decode
  assign addr_phase = i_hsel && i_htrans[1] && i_hready;
  assign rd_req = addr_phase && !i_hwrite;
  assign wr_req = addr_phase && i_hwrite;
  assign ap_addr = {i_haddr[DEC_W-1:2], 2'b00};

  // Data phase write strobes
  assign wr_run = wr_pend_r && (wr_addr_r == RUN_GATE_OFS);
  assign wr_sleep = wr_pend_r && (wr_addr_r == SLEEP_GATE_OFS);
  assign wr_deep = wr_pend_r && (wr_addr_r == DEEP_GATE_OFS);
  assign wr_cfg = wr_pend_r && (wr_addr_r == RUN_CLK_CFG_OFS);
  assign wr_en = wr_pend_r && (wr_addr_r == IRQ_ENABLE_OFS);
  assign wr_clr = wr_pend_r && (wr_addr_r == IRQ_CLEAR_OFS);

  // Only bits with a unit behind them are stored
  assign wdata_gate = i_hwdata & GATE_WMASK;

  // Values as they stand after a write in this cycle, for read forwarding
  assign cur_run = wr_run ? wdata_gate : run_gate_enables_one_r;
  assign cur_sleep = wr_sleep ? wdata_gate : sleep_gate_enables_one_r;
  assign cur_deep = wr_deep ? wdata_gate : deep_sleep_gate_enables_one_r;
  assign cur_cfg = wr_cfg ? (i_hwdata & (32'h00000001 << AUTO_GATING_BIT)) : run_clock_config_r;
  assign cur_en = wr_en ? (i_hwdata & GATE_WMASK) : irq_enable_r;

  // Mode selection
  assign auto_gating_select = run_clock_config_r[AUTO_GATING_BIT];
  assign mode = i_deep_sleep ? MODE_DEEP : (i_sleep ? MODE_SLEEP : MODE_RUN);

  always_comb
  begin
    gate_en_nxt = run_gate_enables_one_r;
    unique case (mode)
      MODE_RUN:
      begin
        gate_en_nxt = run_gate_enables_one_r;
      end
      MODE_SLEEP:
      begin
        gate_en_nxt = auto_gating_select ? sleep_gate_enables_one_r
                                         : run_gate_enables_one_r;
      end
      MODE_DEEP:
      begin
        gate_en_nxt = auto_gating_select ? deep_sleep_gate_enables_one_r
                                         : run_gate_enables_one_r;
      end
      default:
      begin
        gate_en_nxt = run_gate_enables_one_r;
      end
    endcase
  end

  // Faults for accesses to gated-off units
  assign fault_nxt = i_unit_access & GATE_WMASK & ~o_gate_en;
  assign clr_mask = wr_clr ? i_hwdata : ZERO_WORD;
  assign irq_status_nxt = (irq_status_r & ~clr_mask) | fault_nxt;

  // Read mux
  always_comb
  begin
    rd_nxt = ZERO_WORD;
    if (rd_req)
    begin
      if (ap_addr == RUN_GATE_OFS)
      begin
        rd_nxt = cur_run;
      end
      else if (ap_addr == SLEEP_GATE_OFS)
      begin
        rd_nxt = cur_sleep;
      end
      else if (ap_addr == DEEP_GATE_OFS)
      begin
        rd_nxt = cur_deep;
      end
      else if (ap_addr == RUN_CLK_CFG_OFS)
      begin
        rd_nxt = cur_cfg;
      end
      else if (ap_addr == IRQ_STATUS_OFS)
      begin
        rd_nxt = irq_status_nxt;
      end
      else if (ap_addr == IRQ_ENABLE_OFS)
      begin
        rd_nxt = cur_en;
      end
      else
      begin
        rd_nxt = ZERO_WORD;
      end
    end
  end

  // Bus slave state
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= ZERO_WORD;
    end
    else if (i_ce)
    begin
      wr_pend_r <= wr_req;
      wr_addr_r <= ap_addr;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= rd_nxt;
    end
  end

  // Run-mode gate register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      run_gate_enables_one_r <= GATE_RESET;
    end
    else if (i_ce)
    begin
      run_gate_enables_one_r <= cur_run;
    end
  end

  // Sleep-mode gate register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sleep_gate_enables_one_r <= GATE_RESET;
    end
    else if (i_ce)
    begin
      sleep_gate_enables_one_r <= cur_sleep;
    end
  end

  // Deep-sleep gate register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      deep_sleep_gate_enables_one_r <= GATE_RESET;
    end
    else if (i_ce)
    begin
      deep_sleep_gate_enables_one_r <= cur_deep;
    end
  end

  // Run clock configuration, auto gating bit only
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      run_clock_config_r <= CFG_RESET;
    end
    else if (i_ce)
    begin
      run_clock_config_r <= cur_cfg;
    end
  end

  // Registered enables, one cycle after the write completes
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_gate_en <= GATE_RESET;
    end
    else if (i_ce)
    begin
      o_gate_en <= gate_en_nxt & GATE_WMASK;
    end
  end

  // Sticky status and interrupt enables
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      irq_status_r <= ZERO_WORD;
      irq_enable_r <= ZERO_WORD;
    end
    else if (i_ce)
    begin
      irq_status_r <= irq_status_nxt;
      irq_enable_r <= cur_en;
    end
  end

  // Fault and interrupt outputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_access_fault <= 1'b0;
      o_fault_units <= ZERO_WORD;
      o_irq <= 1'b0;
    end
    else if (i_ce)
    begin
      o_access_fault <= |fault_nxt;
      o_fault_units <= fault_nxt;
      o_irq <= |(irq_status_nxt & cur_en);
    end
  end
endmodule

// ---- tb/gate_ctrl_props.sv ----
`timescale 1ns/10ps
module gate_ctrl_props
  import gate_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic i_sleep,
  input wire logic i_deep_sleep,
  input wire logic [31:0] i_unit_access,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic [31:0] o_gate_en,
  input wire logic o_access_fault,
  input wire logic [31:0] o_fault_units,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic [31:0] bad_units = i_unit_access & ~o_gate_en & GATE_WMASK;
  wire logic take = i_hsel & i_htrans[1] & i_hready & i_ce;
  logic sleep_q;
  logic deep_q;
  wire logic mode_chg;
  always_ff @(posedge i_clk)
  begin
    if (i_ce)
    begin
      sleep_q <= i_sleep;
      deep_q <= i_deep_sleep;
    end
  end
  assign mode_chg = i_ce && (i_sleep != sleep_q || i_deep_sleep != deep_q);
  property p_ready; o_hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; !o_hresp; endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_mask; (o_gate_en & ~GATE_WMASK) == ZERO_WORD; endproperty
  a_mask: assert property (p_mask) else $error("unmapped gate bit set");
  property p_fault; i_ce && bad_units != ZERO_WORD |=> o_access_fault; endproperty
  a_fault: assert property (p_fault) else $error("missing fault");
  property p_nofault; i_ce && bad_units == ZERO_WORD |=> !o_access_fault; endproperty
  a_nofault: assert property (p_nofault) else $error("spurious fault");
  property p_units; i_ce |=> o_fault_units == $past(bad_units); endproperty
  a_units: assert property (p_units) else $error("fault units wrong");
  property p_rst; disable iff (1'b0) i_rst |=> o_gate_en == ZERO_WORD && !o_irq; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_idle; !(take && !i_hwrite) |=> o_hrdata == ZERO_WORD; endproperty
  a_idle: assert property (p_idle) else $error("read data outside data phase");
  property p_chg; $changed(o_gate_en) |-> $past(take, 3) || $past(mode_chg); endproperty
  a_chg: assert property (p_chg) else $error("gate changed without cause");
endmodule

bind gate_ctrl gate_ctrl_props props (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_ce(i_ce),
  .i_hsel(i_hsel),
  .i_htrans(i_htrans),
  .i_hwrite(i_hwrite),
  .i_hready(i_hready),
  .i_sleep(i_sleep),
  .i_deep_sleep(i_deep_sleep),
  .i_unit_access(i_unit_access),
  .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp),
  .o_hrdata(o_hrdata),
  .o_gate_en(o_gate_en),
  .o_access_fault(o_access_fault),
  .o_fault_units(o_fault_units),
  .o_irq(o_irq)
);

// ---- tb/gate_ctrl_bench.sv ----
`timescale 1ns/10ps
module gate_ctrl_bench;
  import gate_ctrl_pkg::*;
  logic i_clk = 0, i_rst = 1, i_ce = 1, i_hsel = 0, i_hwrite = 0, i_sleep = 0, i_deep_sleep = 0;
  logic [1:0] i_htrans = 2'h0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, i_unit_access = 32'h0, o_hrdata;
  logic [31:0] o_gate_en, o_fault_units;
  logic o_hreadyout, o_hresp, o_access_fault, o_irq;
  logic [11:0] ofs [6] = '{DEEP_GATE_OFS, RUN_GATE_OFS, SLEEP_GATE_OFS, RUN_CLK_CFG_OFS,
    IRQ_STATUS_OFS, IRQ_ENABLE_OFS};
  int err_count = 0, total_checks = 0;
  gate_ctrl dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(3'h2),
    .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout),
    .i_sleep(i_sleep),
    .i_deep_sleep(i_deep_sleep),
    .i_unit_access(i_unit_access),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .o_gate_en(o_gate_en),
    .o_access_fault(o_access_fault),
    .o_fault_units(o_fault_units),
    .o_irq(o_irq)
  );
  initial forever #2.5 i_clk = ~i_clk;
  task automatic close_out();
    if (err_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (o_hreadyout !== 1'b1 && n < 50);
    if (o_hreadyout !== 1'b1)
    begin
      chk(32'h0, 32'h1);
      close_out();
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] q);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {20'h0, a};
    i_hwrite <= w;
    wait_rdy();
    i_hsel <= 1'b0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    wait_rdy();
    q = o_hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  task automatic hit(input logic [31:0] u);
    i_unit_access <= u;
    @(posedge i_clk);
    i_unit_access <= 32'h0;
    @(posedge i_clk);
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk(o_gate_en, 32'h0);
    foreach (ofs[k]) rdc(ofs[k], 32'h0);
    wr(DEEP_GATE_OFS, 32'hFFFFFFFF);
    rdc(DEEP_GATE_OFS, GATE_WMASK);
    rdc(12'h3FC, 32'h0);
    wr(SLEEP_GATE_OFS, 32'h00010000);
    wr(RUN_GATE_OFS, 32'h01000000);
    i_deep_sleep <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(o_gate_en, 32'h01000000);
    wr(RUN_CLK_CFG_OFS, 32'h08000000);
    repeat (2) @(posedge i_clk);
    chk(o_gate_en, GATE_WMASK);
    i_deep_sleep <= 1'b0;
    i_sleep <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(o_gate_en, 32'h00010000);
    i_sleep <= 1'b0;
    wr(IRQ_ENABLE_OFS, 32'h00010000);
    hit(32'h01010008);
    chk(o_access_fault, 32'h1);
    chk(o_fault_units, 32'h00010000);
    chk(o_irq, 32'h1);
    rdc(IRQ_STATUS_OFS, 32'h00010000);
    wr(IRQ_CLEAR_OFS, 32'h00010000);
    hit(32'h00020000);
    chk(o_irq, 32'h0);
    rdc(IRQ_STATUS_OFS, 32'h00020000);
    i_ce <= 1'b0;
    i_deep_sleep <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(o_gate_en, 32'h01000000);
    i_ce <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk(o_gate_en, GATE_WMASK);
    close_out();
  end
endmodule
